// *** hw/lsag_pkg.sv ***
// constants and types shared by the load/store address generation logic
package lsag_pkg;
  // =====================================================================
  // instruction field positions
  localparam int OP_HI     = 31;
  localparam int OP_LO     = 30;
  localparam int RD_HI     = 29;
  localparam int RD_LO     = 25;
  localparam int OP2_HI    = 24;
  localparam int OP2_LO    = 22;
  localparam int OP3_HI    = 24;
  localparam int OP3_LO    = 19;
  localparam int SRC1_HI   = 18;
  localparam int SRC1_LO   = 14;
  localparam int IMM_BIT   = 13;
  localparam int ASI_HI    = 12;
  localparam int ASI_LO    = 5;
  localparam int SRC2_HI   = 4;
  localparam int SRC2_LO   = 0;
  localparam int IMM13_HI  = 12;
  localparam int DISP22_HI = 21;
  localparam int DISP30_HI = 29;
  // =====================================================================
  // opcode encodings
  localparam logic [1:0] OP_FMT2  = 2'h0;
  localparam logic [1:0] OP_CALL  = 2'h1;
  localparam logic [1:0] OP_ARITH = 2'h2;
  localparam logic [1:0] OP_MEM   = 2'h3;
  localparam logic [2:0] OP2_INT_BRANCH    = 3'h2;
  localparam logic [2:0] OP2_FLOAT_BRANCH  = 3'h6;
  localparam logic [2:0] OP2_COPROC_BRANCH = 3'h7;
  localparam logic [5:0] OP3_JUMP_LINK   = 6'h38;
  localparam logic [5:0] OP3_TRAP_RETURN = 6'h39;
  localparam logic [5:0] OP3_TRAP_COND   = 6'h3A;
  localparam logic [1:0] CLASS_FLOAT  = 2'h2;
  localparam logic [1:0] CLASS_COPROC = 2'h3;
  localparam logic [3:0] LOW_ATOMIC_BYTE = 4'hD;
  localparam logic [3:0] LOW_SWAP        = 4'hF;
  localparam logic [1:0] LOW_BYTE   = 2'h1;
  localparam logic [1:0] LOW_HALF   = 2'h2;
  localparam logic [1:0] LOW_QUEUE  = 2'h2;
  localparam logic [1:0] LOW_DOUBLE = 2'h3;
  // =====================================================================
  // address space identifiers and access encodings
  localparam logic [7:0] ASI_USER_INSTR = 8'h08;
  localparam logic [7:0] ASI_USER_DATA  = 8'h0A;
  localparam logic [7:0] ASI_SUP_INSTR  = 8'h09;
  localparam logic [7:0] ASI_SUP_DATA   = 8'h0B;
  localparam logic [1:0] SIZE_BYTE   = 2'h0;
  localparam logic [1:0] SIZE_HALF   = 2'h1;
  localparam logic [1:0] SIZE_WORD   = 2'h2;
  localparam logic [1:0] SIZE_DOUBLE = 2'h3;
  localparam logic [1:0] OWNER_INT    = 2'h0;
  localparam logic [1:0] OWNER_FLOAT  = 2'h1;
  localparam logic [1:0] OWNER_COPROC = 2'h2;
  // =====================================================================
  // cycle counts, reset values
  localparam logic [2:0] CYC_SINGLE       = 3'h1;
  localparam logic [2:0] CYC_LOAD         = 3'h2;
  localparam logic [2:0] CYC_LOAD_DOUBLE  = 3'h3;
  localparam logic [2:0] CYC_STORE        = 3'h3;
  localparam logic [2:0] CYC_STORE_DOUBLE = 3'h4;
  localparam logic [2:0] CYC_ATOMIC       = 3'h4;
  localparam logic [31:0] PC_STEP   = 32'h4;
  localparam logic [31:0] ZERO_WORD = 32'h0;
  localparam logic [4:0]  REG_ZERO  = 5'h00;
  // issue sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_DEFER, ST_BUSY} seq_state_type;
endpackage

// *** hw/load_store_address_generation.sv ***
// address generation and load/store issue sequencing of the integer unit
`timescale 1ns/1ns
`default_nettype none
module load_store_address_generation
  import lsag_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // instruction issue
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  input  wire logic [31:0] pc,
  input  wire logic        supervisor,
  input  wire logic [31:0] first_source_value,
  input  wire logic [31:0] second_source_value,
  output logic             instr_ready,
  // data access
  output logic             mem_valid,
  output logic [31:0]      mem_addr,
  output logic [7:0]       mem_asi,
  output logic             mem_write,
  output logic             mem_atomic,
  output logic [1:0]       mem_size,
  output logic [1:0]       data_owner,
  // fetch space
  output logic [7:0]       fetch_asi,
  // control flow
  output logic [31:0]      next_program_counter,
  output logic             next_pc_load,
  // status
  output logic             priv_trap,
  output logic             load_wb_valid,
  output logic [4:0]       load_wb_index
);
  // =====================================================================
  // decode helpers
  // size of a memory access from its opcode
  function automatic logic [1:0] size_of(input logic [5:0] op3);
    logic [1:0] sz;
    sz = SIZE_WORD;
    if (op3[5]) begin
      // float/coprocessor: word, status word, queue, double
      if (op3[1:0] == LOW_DOUBLE || (op3[2] && op3[1:0] == LOW_QUEUE)) begin
        sz = SIZE_DOUBLE;
      end
    end else if (op3[3:0] == LOW_SWAP) begin
      sz = SIZE_WORD;
    end else if (op3[1:0] == LOW_BYTE) begin
      sz = SIZE_BYTE;
    end else if (op3[1:0] == LOW_HALF) begin
      sz = SIZE_HALF;
    end else if (op3[1:0] == LOW_DOUBLE) begin
      sz = SIZE_DOUBLE;
    end
    return sz;
  endfunction

  // register pair aware match for the load-use check
  function automatic logic reg_match(input logic [4:0] a, input logic [4:0] b,
                                     input logic dbl);
    return dbl ? (a[4:1] == b[4:1]) : (a == b);
  endfunction

  // =====================================================================
  // state
  seq_state_type state_reg;            // issue sequencer
  seq_state_type state_next;
  logic [31:0]   held_instr_reg;       // instruction stalled by hazard
  logic [2:0]    remain_reg;           // cycles left before next issue
  logic          ld_live_reg;          // last issue was a register load
  logic [4:0]    ld_rd_reg;            // its destination
  logic          ld_dbl_reg;           // destination is a pair
  logic          wb_pend_reg;          // writeback due at completion
  logic [4:0]    wb_idx_reg;

  // =====================================================================
  // field extraction
  logic [31:0] cur;                    // instruction being issued
  logic [1:0]  op_f;
  logic [2:0]  op2_f;
  logic [5:0]  op3_f;
  logic [4:0]  rd_f;
  logic [4:0]  first_source_reg_field;
  logic [4:0]  second_source_reg_field;
  logic [12:0] signed_imm13_field;
  logic [7:0]  asi_f;
  logic        imm_f;

  // deferred issue re-reads the held word, operands stay live
  assign cur = (state_reg == ST_DEFER) ? held_instr_reg : instr;
  assign op_f = cur[OP_HI:OP_LO];
  assign op2_f = cur[OP2_HI:OP2_LO];
  assign op3_f = cur[OP3_HI:OP3_LO];
  assign rd_f = cur[RD_HI:RD_LO];
  assign first_source_reg_field = cur[SRC1_HI:SRC1_LO];
  assign second_source_reg_field = cur[SRC2_HI:SRC2_LO];
  assign signed_imm13_field = cur[IMM13_HI:0];
  assign asi_f = cur[ASI_HI:ASI_LO];
  assign imm_f = cur[IMM_BIT];

  // =====================================================================
  // classification
  logic is_mem;                        // load or store
  logic is_alt;                        // alternate space form
  logic is_atomic;                     // atomic byte set or swap
  logic is_store;
  logic is_dbl_ld;                     // double-word access, load or store
  logic is_indirect;                   // jump, return, conditional trap
  logic is_call;
  logic is_branch;
  logic trap_hit;                      // user alternate access
  logic [2:0] cyc;                     // issue-to-issue cycles

  assign is_mem = (op_f == OP_MEM);
  assign is_alt = is_mem && !op3_f[5] && op3_f[4];
  assign is_atomic = is_mem && !op3_f[5] &&
                     (op3_f[3:0] == LOW_ATOMIC_BYTE || op3_f[3:0] == LOW_SWAP);
  assign is_store = op3_f[2] && !is_atomic;
  assign is_dbl_ld = (size_of(op3_f) == SIZE_DOUBLE);
  assign is_indirect = (op_f == OP_ARITH) && (op3_f == OP3_JUMP_LINK ||
                       op3_f == OP3_TRAP_RETURN || op3_f == OP3_TRAP_COND);
  assign is_call = (op_f == OP_CALL);
  assign is_branch = (op_f == OP_FMT2) && (op2_f == OP2_INT_BRANCH ||
                     op2_f == OP2_FLOAT_BRANCH || op2_f == OP2_COPROC_BRANCH);
  assign trap_hit = is_alt && !supervisor;

  // cycle count per access kind
  always_comb begin
    cyc = CYC_SINGLE;
    if (is_mem && !trap_hit) begin
      if (is_atomic) begin
        cyc = CYC_ATOMIC;
      end else if (is_store) begin
        cyc = is_dbl_ld ? CYC_STORE_DOUBLE : CYC_STORE;
      end else begin
        cyc = is_dbl_ld ? CYC_LOAD_DOUBLE : CYC_LOAD;
      end
    end
  end

  // =====================================================================
  // operand and address arithmetic
  logic [31:0] src1;
  logic [31:0] src2;
  logic [31:0] imm_ext;
  logic [31:0] addr_sum;
  logic [31:0] call_disp;
  logic [31:0] branch_disp;

  // register zero contributes zero whatever the file says
  assign src1 = (first_source_reg_field == REG_ZERO) ? ZERO_WORD : first_source_value;
  assign imm_ext = {{19{signed_imm13_field[12]}}, signed_imm13_field};
  // alternate space ignores the immediate form
  assign src2 = (imm_f && !is_alt) ? imm_ext :
                ((second_source_reg_field == REG_ZERO) ? ZERO_WORD : second_source_value);
  assign addr_sum = src1 + src2;
  assign call_disp = {cur[DISP30_HI:0], 2'h0};
  assign branch_disp = {{8{cur[DISP22_HI]}}, cur[DISP22_HI:0], 2'h0};

  // =====================================================================
  // handshake and load-use hazard
  logic take;                          // request accepted this edge
  logic hazard;                        // taken word reads pending load
  logic issue;                         // word executes this edge

  assign take = instr_valid && instr_ready && (state_reg == ST_IDLE);
  assign hazard = ld_live_reg && op_f[1] &&
                  (reg_match(first_source_reg_field, ld_rd_reg, ld_dbl_reg) ||
                   ((!imm_f || is_alt) &&
                    reg_match(second_source_reg_field, ld_rd_reg, ld_dbl_reg)) ||
                   (is_mem && op3_f[2] && reg_match(rd_f, ld_rd_reg, ld_dbl_reg)));
  assign issue = (take && !hazard) || (state_reg == ST_DEFER);

  // next sequencer state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take && hazard) begin
          state_next = ST_DEFER;
        end else if (take && cyc > CYC_SINGLE) begin
          state_next = ST_BUSY;
        end
      end
      ST_DEFER: begin
        state_next = (cyc > CYC_SINGLE) ? ST_BUSY : ST_IDLE;
      end
      ST_BUSY: begin
        if (remain_reg == CYC_SINGLE) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer and ready flag, ready mirrors the idle state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      instr_ready <= 1'b1;
    end else begin
      state_reg <= state_next;
      instr_ready <= (state_next == ST_IDLE);
    end
  end

  // remaining busy cycles after the issue edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      remain_reg <= CYC_SINGLE;
    end else if (issue) begin
      remain_reg <= cyc - CYC_SINGLE;
    end else if (state_reg == ST_BUSY) begin
      remain_reg <= remain_reg - CYC_SINGLE;
    end
  end

  // hold the word stalled by the interlock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      held_instr_reg <= ZERO_WORD;
    end else if (take && hazard) begin
      held_instr_reg <= instr;
    end
  end

  // pending load tracker, consumed by the first idle cycle after it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ld_live_reg <= 1'b0;
      ld_rd_reg <= REG_ZERO;
      ld_dbl_reg <= 1'b0;
    end else if (issue) begin
      // loads into register zero never create a hazard
      ld_live_reg <= is_mem && !trap_hit && !op3_f[5] && !is_store &&
                     (rd_f != REG_ZERO);
      ld_rd_reg <= rd_f;
      ld_dbl_reg <= is_dbl_ld;
    end else if (state_reg == ST_IDLE) begin
      ld_live_reg <= 1'b0;
    end
  end

  // =====================================================================
  // memory access outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_valid <= 1'b0;
      mem_addr <= ZERO_WORD;
      mem_asi <= ASI_SUP_DATA;
      mem_write <= 1'b0;
      mem_atomic <= 1'b0;
      mem_size <= SIZE_WORD;
      data_owner <= OWNER_INT;
    end else begin
      // privileged violation suppresses the strobe only; address, space, size and kind still load
      mem_valid <= issue && is_mem && !trap_hit;
      if (issue && is_mem) begin
        mem_addr <= addr_sum;
        if (is_alt) begin
          mem_asi <= asi_f;
        end else begin
          mem_asi <= supervisor ? ASI_SUP_DATA : ASI_USER_DATA;
        end
        mem_write <= is_store;
        mem_atomic <= is_atomic;
        mem_size <= size_of(op3_f);
        // attached unit moves the data, only the address is ours
        if (op3_f[5:4] == CLASS_FLOAT) begin
          data_owner <= OWNER_FLOAT;
        end else if (op3_f[5:4] == CLASS_COPROC) begin
          data_owner <= OWNER_COPROC;
        end else begin
          data_owner <= OWNER_INT;
        end
      end
    end
  end

  // fetch space tracks the mode every cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fetch_asi <= ASI_SUP_INSTR;
    end else begin
      fetch_asi <= supervisor ? ASI_SUP_INSTR : ASI_USER_INSTR;
    end
  end

  // =====================================================================
  // control transfer targets
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      next_program_counter <= ZERO_WORD;
      next_pc_load <= 1'b0;
    end else begin
      next_pc_load <= issue && (is_call || is_branch || is_indirect);
      if (issue && is_call) begin
        next_program_counter <= pc + PC_STEP + call_disp;
      end else if (issue && is_branch) begin
        next_program_counter <= pc + PC_STEP + branch_disp;
      end else if (issue && is_indirect) begin
        // low bits dropped so a stray offset cannot misalign fetch
        next_program_counter <= {addr_sum[31:2], 2'h0};
      end
    end
  end

  // =====================================================================
  // trap and load writeback
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      priv_trap <= 1'b0;
    end else begin
      priv_trap <= issue && trap_hit;
    end
  end

  // writeback announced in the first ready cycle after an integer load
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_pend_reg <= 1'b0;
      wb_idx_reg <= REG_ZERO;
      load_wb_valid <= 1'b0;
      load_wb_index <= REG_ZERO;
    end else begin
      if (issue) begin
        wb_pend_reg <= is_mem && !trap_hit && !op3_f[5] && !is_store &&
                       (rd_f != REG_ZERO);
        wb_idx_reg <= rd_f;
      end
      load_wb_valid <= wb_pend_reg && (state_reg == ST_BUSY) &&
                       (remain_reg == CYC_SINGLE);
      load_wb_index <= wb_idx_reg;
    end
  end

  // =====================================================================
  // checks
  a_two_reg_addr: assert property (@(posedge clock) disable iff (rst)
    issue && is_mem && !trap_hit && (is_alt || !imm_f) &&
    first_source_reg_field != REG_ZERO && second_source_reg_field != REG_ZERO
    |=> mem_addr == $past(first_source_value) + $past(second_source_value))
    else $error("two-register address wrong");
  a_imm_addr: assert property (@(posedge clock) disable iff (rst)
    issue && is_mem && imm_f && !is_alt && first_source_reg_field == REG_ZERO
    |=> mem_addr == $past(imm_ext))
    else $error("immediate-only address wrong");
  a_call_target: assert property (@(posedge clock) disable iff (rst)
    issue && is_call
    |=> next_pc_load && next_program_counter == $past(pc) + PC_STEP + $past(call_disp))
    else $error("call target wrong");
  a_target_align: assert property (@(posedge clock) disable iff (rst)
    next_pc_load |-> next_program_counter[1:0] == 2'h0)
    else $error("target not word aligned");
  a_data_asi: assert property (@(posedge clock) disable iff (rst)
    issue && is_mem && !is_alt
    |=> mem_asi == ($past(supervisor) ? ASI_SUP_DATA : ASI_USER_DATA))
    else $error("automatic data space wrong");
  a_alt_asi: assert property (@(posedge clock) disable iff (rst)
    issue && is_alt && supervisor |=> mem_valid && mem_asi == $past(asi_f))
    else $error("alternate space identifier wrong");
  a_alt_priv: assert property (@(posedge clock) disable iff (rst)
    issue && trap_hit |=> priv_trap && !mem_valid)
    else $error("user alternate access not trapped");
  a_load_cycles: assert property (@(posedge clock) disable iff (rst)
    mem_valid && !mem_write && !mem_atomic && mem_size != SIZE_DOUBLE
    |-> !instr_ready ##1 instr_ready)
    else $error("single load cycle count wrong");
  a_store_cycles: assert property (@(posedge clock) disable iff (rst)
    mem_valid && mem_write && mem_size != SIZE_DOUBLE
    |-> !instr_ready [*2] ##1 instr_ready)
    else $error("single store cycle count wrong");
  a_atomic_cycles: assert property (@(posedge clock) disable iff (rst)
    mem_valid && mem_atomic |-> !instr_ready [*3] ##1 instr_ready)
    else $error("atomic cycle count wrong");
  a_interlock_stall: assert property (@(posedge clock) disable iff (rst)
    take && hazard |=> !instr_ready && !mem_valid ##1 state_reg != ST_DEFER)
    else $error("load-use stall wrong");
  c_call: cover property (@(posedge clock) disable iff (rst) issue && is_call);
  c_alt_ok: cover property (@(posedge clock) disable iff (rst) issue && is_alt && supervisor);
  c_hazard: cover property (@(posedge clock) disable iff (rst) take && hazard);
  c_atomic: cover property (@(posedge clock) disable iff (rst) mem_valid && mem_atomic);
endmodule
`default_nettype wire

// *** sim/mem_system_model.sv ***
// passive memory system model counting the data accesses it serves
`timescale 1ns/1ns
`default_nettype none
module mem_system_model
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // data access strobe from the block
  input  wire logic        mem_valid,
  // observed traffic
  output logic [15:0]      access_count
);
  // =====================================================================
  // one served access per strobe; float and coprocessor data is left to
  // the attached unit, so only the address phase is seen here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      access_count <= 16'h0000;
    end else if (mem_valid) begin
      access_count <= access_count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the load/store address generation block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lsag_pkg::*;
  // =====================================================================
  // connections
  logic        clock, rst, instr_valid, supervisor;         // stimulus
  logic [31:0] instr, pc, first_source_value, second_source_value; // operands
  logic        instr_ready, mem_valid, mem_write, mem_atomic;
  logic        next_pc_load, priv_trap, load_wb_valid;
  logic [31:0] mem_addr, next_program_counter;
  logic [7:0]  mem_asi, fetch_asi;
  logic [1:0]  mem_size, data_owner;
  logic [4:0]  load_wb_index;
  logic [15:0] access_count;                                // served accesses
  int          errors, comparisons;
  // op3, cycles, size, {write, atomic, owner}
  localparam logic [19:0] OPS [21] = '{20'h00220, 20'h01200, 20'h02210,
    20'h03330, 20'h04328, 20'h05308, 20'h06318, 20'h07438, 20'h09200,
    20'h0A210, 20'h0D404, 20'h0F424, 20'h20221, 20'h21221, 20'h23331,
    20'h24329, 20'h26439, 20'h27439, 20'h30222, 20'h3432A, 20'h3743A};
  load_store_address_generation DUT (.clock, .rst, .instr_valid, .instr, .pc,
    .supervisor, .first_source_value, .second_source_value, .instr_ready,
    .mem_valid, .mem_addr, .mem_asi, .mem_write, .mem_atomic, .mem_size,
    .data_owner, .fetch_asi,
    .next_program_counter, .next_pc_load, .priv_trap, .load_wb_valid,
    .load_wb_index);
  mem_system_model memory (.clock, .rst, .mem_valid, .access_count);
  // =====================================================================
  // shared tasks
  task automatic finish_test;
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // count cycles from the take edge until ready returns
  task automatic done_in(input int start, input int exp);
    int n;
    n = start;
    while (instr_ready !== 1'b1) begin
      if (n > 20) begin
        errors++;
        finish_test;
      end
      @(negedge clock);
      n++;
    end
    check(n, exp);
  endtask
  // offer a word, hold it until ready is seen, release at the take edge;
  // ready is read mid-cycle so a value launched on this edge is not missed
  task automatic issue(input logic [31:0] w, input logic s,
                       input logic [31:0] a, input logic [31:0] b);
    int n;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr <= w;
    supervisor <= s;
    first_source_value <= a;
    second_source_value <= b;
    n = 0;
    @(negedge clock);
    while (instr_ready !== 1'b1) begin
      if (n > 20) begin
        errors++;
        finish_test;
      end
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    instr_valid <= 1'b0;
  endtask
  // =====================================================================
  // scenarios
  task automatic s_mem_table;
    logic [19:0] e;
    logic [31:0] w;
    int          n;
    for (int v = 0; v < 4; v++) begin
      foreach (OPS[k]) begin
        e = OPS[k];
        if (v < 2 || e[19:12] < 8'h10) begin
          w = {2'h3, 5'h07, e[17:12] | (v > 1 ? 6'h10 : 6'h00), 5'h01, v != 1,
               v == 0 ? 13'h1FFD : (v == 1 ? 13'h0003 : {8'h5A, 5'h03})};
          n = access_count;
          issue(w, v == 1 || v == 2, v == 0 ? 32'h2000_0001 : 32'h100, 32'h23);
          @(negedge clock);
          if (v == 3) begin
            check(priv_trap, 1'b1);
            check(mem_valid, 1'b0);
            done_in(1, 1);
            // a wrongly raised strobe is only counted one edge later
            @(negedge clock);
            check(access_count, n);
          end else begin
            check(mem_valid, 1'b1);
            check(mem_addr, v == 0 ? 32'h1FFF_FFFE : 32'h123);
            check(mem_asi, v == 0 ? ASI_USER_DATA : (v == 1 ? ASI_SUP_DATA : 8'h5A));
            check(fetch_asi, v == 0 ? ASI_USER_INSTR : ASI_SUP_INSTR);
            check(mem_size, e[5:4]);
            check({mem_write, mem_atomic, data_owner}, e[3:0]);
            done_in(1, e[11:8]);
            check(access_count, n + 1);
          end
        end
      end
    end
  endtask
  task automatic s_absolute;
    issue({2'h3, 5'h07, 6'h00, 5'h00, 1'b1, 13'h1000}, 1'b0, 32'hDEAD_BEEF, 32'h0);
    @(negedge clock);
    check(mem_addr, 32'hFFFF_F000);
    done_in(1, 2);
    check(load_wb_valid, 1'b1);
    check(load_wb_index, 5'h07);
    issue({2'h3, 5'h00, 6'h00, 5'h00, 1'b1, 13'h0FFF}, 1'b0, 32'hDEAD_BEEF, 32'h0);
    @(negedge clock);
    check(mem_addr, 32'h0000_0FFF);
    done_in(1, 2);
    check(load_wb_valid, 1'b0);
  endtask
  // a load followed at once by a load whose base is src
  task automatic s_chain(input logic [4:0] src, input int lag);
    issue({2'h3, 5'h07, 6'h00, 5'h01, 1'b1, 13'h0004}, 1'b0, 32'h40, 32'h0);
    @(negedge clock);
    issue({2'h3, 5'h08, 6'h00, src, 1'b1, 13'h0004}, 1'b0, 32'h80, 32'h0);
    repeat (lag) @(negedge clock);
    check(mem_valid, 1'b1);
    check(mem_addr, 32'h84);
    done_in(lag, lag + 1);
  endtask
  task automatic s_target(input logic [31:0] w, input logic [31:0] p,
                          input logic [31:0] exp);
    @(posedge clock);
    pc <= p;
    issue(w, 1'b1, 32'h1003, 32'h2);
    @(negedge clock);
    check(next_pc_load, 1'b1);
    check(next_program_counter, exp);
    check(mem_valid, 1'b0);
  endtask
  // =====================================================================
  // clock and main sequence
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {instr_valid, supervisor, instr, pc, first_source_value, second_source_value} = '0;
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check(instr_ready, 1'b1);
    check({mem_asi, fetch_asi}, {ASI_SUP_DATA, ASI_SUP_INSTR});
    @(posedge clock);
    rst <= 1'b0;
    s_mem_table;
    s_absolute;
    s_chain(5'h07, 2);
    s_chain(5'h09, 1);
    s_target({2'h1, 30'h3FFF_FFFF}, 32'h1000, 32'h1000);
    s_target({2'h1, 30'h0000_0010}, 32'h1000, 32'h1044);
    s_target({2'h0, 5'h08, 3'h2, 22'h20_0000}, 32'h0100_0000, 32'h0080_0004);
    s_target({2'h0, 5'h08, 3'h6, 22'h1F_FFFF}, 32'h0, 32'h0080_0000);
    s_target({2'h0, 5'h08, 3'h7, 22'h00_0001}, 32'h10, 32'h18);
    s_target({2'h2, 5'h00, 6'h38, 5'h01, 1'b0, 13'h0002}, 32'h0, 32'h1004);
    finish_test;
  end
endmodule
`default_nettype wire
